// ### verilog/odc_ctrl.sv
// debug control/status registers, apb slave and execute-command front end
`timescale 1ns/100ps
`default_nettype none
`include "odc_consts.svh"

// Notes on behaviour
// - debug flag set: core stops fetching new instructions
// - clearing debug flag lets the core fetch and run again
// - breakpoint enabled and break opcode decoded sets the debug flag
// - read protect on: writes of zero to debug flag are ignored
// - breakpoint disabled: break opcode 00h acts as no-operation
// - ack enable and a breakpoint: send character ffh to the host
// - reset request bit resets all but debug unit, self-clears, zero ignored
// - 81h resets and stops, 41h resets and runs, 40h resumes
// - status is read-only: bit7 debug, bit6 halt, bit5 read-protect, rest zero
// - read-protect status reads 0 when protection is in force, else 1
// - exec command 12h with 1-5 opcode bytes; else one byte discarded
module odc_ctrl (
	input  wire logic        clk,           // system clock, 250 mhz
	input  wire logic        reset,         // synchronous reset, active high
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [11:0] paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error, unmapped address
	input  wire logic        flash_read_protect_option, // option pin
	input  wire logic        core_halted,   // core in halt mode, async pin
	input  wire logic        core_decode,   // core decodes an opcode
	input  wire logic [7:0]  core_opcode,   // opcode being decoded
	output logic             core_fetch_stop, // stall core fetch
	output logic             break_as_nop,  // break opcode runs as nop
	output logic             sys_reset,     // reset to all but debug unit
	input  wire logic        link_rx_valid, // byte from host
	input  wire logic [7:0]  link_rx_data,  // received byte
	output logic             link_tx_valid, // byte to host
	output logic      [7:0]  link_tx_data,  // transmitted byte
	input  wire logic        link_tx_ready, // host link takes byte
	output logic             exec_valid,    // opcode byte for the core
	output logic      [7:0]  exec_data,     // opcode byte
	output logic             exec_last,     // last opcode byte
	output logic             irq            // level interrupt
);
	logic                    debug_mode_flag_r;
	logic                    debug_mode_flag_nxt;
	logic                    breakpoint_enable_r;
	logic                    breakpoint_enable_nxt;
	logic                    debug_ack_enable_r;
	logic                    debug_ack_enable_nxt;
	logic                    rst_req_r;
	logic                    rst_req_nxt;
	// cycles left in the reset request; five bits hold the full length
	logic [4:0]              rst_cnt_r;
	logic [4:0]              rst_cnt_nxt;
	// ack byte waits here until the host link takes it
	logic                    ack_pend_r;
	logic                    ack_pend_nxt;
	logic [`ODC_IRQ_W-1:0]   irq_stat_r;
	logic [`ODC_IRQ_W-1:0]   irq_stat_nxt;
	logic [`ODC_IRQ_W-1:0]   irq_mask_r;
	logic [`ODC_IRQ_W-1:0]   irq_mask_nxt;
	logic [31:0]             prdata_r;
	logic [31:0]             prdata_nxt;
	logic                    pslverr_r;
	logic                    pslverr_nxt;
	odc_pkg::odc_cmd_state_t cmd_r;
	odc_pkg::odc_cmd_state_t cmd_nxt;
	logic [2:0]              exec_left_r;
	logic [2:0]              exec_left_nxt;
	logic                    exec_valid_r;
	logic                    exec_valid_nxt;
	logic [7:0]              exec_data_r;
	logic [7:0]              exec_data_nxt;
	logic                    exec_last_r;
	logic                    exec_last_nxt;
	logic                    halt_sync;
	logic                    wr_en;
	logic                    break_hit;
	logic                    protected_now;
	logic [7:0]              ctl_view;
	logic [7:0]              stat_view;

	// the halt level comes from the core's own timing, so it is filtered
	odc_sync odc_sync_inst (
		.clk   (clk),
		.reset (reset),
		.din   (core_halted),
		.dout  (halt_sync)
	);

	function automatic logic addr_hit(input logic [11:0] a,
		input logic [11:0] r);
		addr_hit = (a == r);
	endfunction : addr_hit

	assign wr_en = psel && penable && pwrite;
	assign protected_now = flash_read_protect_option;
	// breaks only count while the core is running
	assign break_hit = core_decode && (core_opcode == `ODC_OPC_BREAK)
		&& breakpoint_enable_r && !debug_mode_flag_r;

	always_comb begin
		ctl_view = 8'h00;
		ctl_view[`ODC_CTL_DEBUG_MODE_FLAG] = debug_mode_flag_r;
		ctl_view[`ODC_CTL_BREAKPOINT_ENABLE]   = breakpoint_enable_r;
		ctl_view[`ODC_CTL_ACKEN]   = debug_ack_enable_r;
		ctl_view[`ODC_CTL_RSTREQ]  = rst_req_r;
		stat_view = 8'h00;
		stat_view[`ODC_STAT_DEBUG]  = debug_mode_flag_r;
		stat_view[`ODC_STAT_HALT]   = halt_sync;
		stat_view[`ODC_STAT_RDPROT] = !protected_now;
	end

	always_comb begin
		debug_mode_flag_nxt   = debug_mode_flag_r;
		breakpoint_enable_nxt = breakpoint_enable_r;
		debug_ack_enable_nxt  = debug_ack_enable_r;
		rst_req_nxt           = rst_req_r;
		rst_cnt_nxt           = rst_cnt_r;
		ack_pend_nxt          = ack_pend_r;
		irq_stat_nxt          = irq_stat_r;
		irq_mask_nxt          = irq_mask_r;

		if (wr_en && addr_hit(paddr, `ODC_ADDR_CTL)) begin
			breakpoint_enable_nxt = pwdata[`ODC_CTL_BREAKPOINT_ENABLE];
			debug_ack_enable_nxt  = pwdata[`ODC_CTL_ACKEN];
			// under read protect only a reset can leave debug mode
			if (pwdata[`ODC_CTL_DEBUG_MODE_FLAG] || !protected_now) begin
				debug_mode_flag_nxt = pwdata[`ODC_CTL_DEBUG_MODE_FLAG];
			end
			if (pwdata[`ODC_CTL_RSTREQ]) begin
				rst_req_nxt = 1'b1;
				// a repeated request restarts the full length
				rst_cnt_nxt = 5'(`ODC_RST_CYCLES);
			end
		end
		if (wr_en && addr_hit(paddr, `ODC_ADDR_IRQ_MASK)) begin
			irq_mask_nxt = pwdata[`ODC_IRQ_W-1:0];
		end
		if (wr_en && addr_hit(paddr, `ODC_ADDR_IRQ_STAT)) begin
			irq_stat_nxt = irq_stat_nxt & ~pwdata[`ODC_IRQ_W-1:0];
		end
		if (rst_req_r && !(wr_en && addr_hit(paddr, `ODC_ADDR_CTL)
			&& pwdata[`ODC_CTL_RSTREQ])) begin
			if (rst_cnt_r <= 5'h1) begin
				rst_req_nxt = 1'b0;
				rst_cnt_nxt = 5'h0;
				irq_stat_nxt[`ODC_IRQ_RSTDONE] = 1'b1;
			end else begin
				rst_cnt_nxt = rst_cnt_r - 5'h1;
			end
		end
		if (break_hit) begin
			debug_mode_flag_nxt = 1'b1;
			irq_stat_nxt[`ODC_IRQ_BREAK] = 1'b1;
			if (debug_ack_enable_r) begin
				ack_pend_nxt = 1'b1;
			end
		end else if (ack_pend_r && link_tx_ready) begin
			ack_pend_nxt = 1'b0;
		end
		if (cmd_r == odc_pkg::ODC_CMD_DROP && link_rx_valid) begin
			irq_stat_nxt[`ODC_IRQ_DISCARD] = 1'b1;
		end
	end

	always_comb begin
		cmd_nxt        = cmd_r;
		exec_left_nxt  = exec_left_r;
		exec_valid_nxt = 1'b0;
		exec_data_nxt  = exec_data_r;
		exec_last_nxt  = 1'b0;

		case (cmd_r)
			odc_pkg::ODC_CMD_IDLE: begin
				if (link_rx_valid && link_rx_data == `ODC_CMD_EXEC) begin
					if (!debug_mode_flag_r || protected_now) begin
						cmd_nxt = odc_pkg::ODC_CMD_DROP;
					end else begin
						cmd_nxt = odc_pkg::ODC_CMD_LEN;
					end
				end
			end
			odc_pkg::ODC_CMD_LEN: begin
				// first byte after the command gives the opcode length
				if (link_rx_valid) begin
					if (link_rx_data[2:0] == 3'h0
						|| link_rx_data[2:0] > `ODC_EXEC_MAX) begin
						cmd_nxt = odc_pkg::ODC_CMD_IDLE;
					end else begin
						exec_left_nxt = link_rx_data[2:0];
						cmd_nxt = odc_pkg::ODC_CMD_OPC;
					end
				end
			end
			odc_pkg::ODC_CMD_OPC: begin
				if (link_rx_valid) begin
					exec_valid_nxt = 1'b1;
					exec_data_nxt  = link_rx_data;
					exec_left_nxt  = exec_left_r - 3'h1;
					if (exec_left_r == 3'h1) begin
						exec_last_nxt = 1'b1;
						cmd_nxt = odc_pkg::ODC_CMD_IDLE;
					end
				end
			end
			odc_pkg::ODC_CMD_DROP: begin
				if (link_rx_valid) begin
					cmd_nxt = odc_pkg::ODC_CMD_IDLE;
				end
			end
			default: begin
				cmd_nxt = odc_pkg::ODC_CMD_IDLE;
			end
		endcase
	end

	always_comb begin
		prdata_nxt  = 32'h0;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			case (paddr)
				`ODC_ADDR_CTL: begin
					prdata_nxt = {24'h0, ctl_view};
				end
				`ODC_ADDR_STAT: begin
					prdata_nxt = {24'h0, stat_view};
				end
				`ODC_ADDR_IRQ_STAT: begin
					prdata_nxt = {29'h0, irq_stat_r};
				end
				`ODC_ADDR_IRQ_MASK: begin
					prdata_nxt = {29'h0, irq_mask_r};
				end
				default: begin
					pslverr_nxt = 1'b1;
				end
			endcase
			// status is read-only: writes there are accepted and dropped
			if (pwrite) begin
				prdata_nxt = 32'h0;
			end
		end else begin
			prdata_nxt  = prdata_r;
			pslverr_nxt = pslverr_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			debug_mode_flag_r   <= 1'b0;
			breakpoint_enable_r <= 1'b0;
			debug_ack_enable_r  <= 1'b0;
			rst_req_r           <= 1'b0;
			rst_cnt_r           <= 5'h0;
			ack_pend_r          <= 1'b0;
			irq_stat_r          <= 3'h0;
			irq_mask_r          <= 3'h0;
			prdata_r            <= 32'h0;
			pslverr_r           <= 1'b0;
			cmd_r               <= odc_pkg::ODC_CMD_IDLE;
			exec_left_r         <= 3'h0;
			exec_valid_r        <= 1'b0;
			exec_data_r         <= 8'h00;
			exec_last_r         <= 1'b0;
		end else begin
			debug_mode_flag_r   <= debug_mode_flag_nxt;
			breakpoint_enable_r <= breakpoint_enable_nxt;
			debug_ack_enable_r  <= debug_ack_enable_nxt;
			rst_req_r           <= rst_req_nxt;
			rst_cnt_r           <= rst_cnt_nxt;
			ack_pend_r          <= ack_pend_nxt;
			irq_stat_r          <= irq_stat_nxt;
			irq_mask_r          <= irq_mask_nxt;
			prdata_r            <= prdata_nxt;
			pslverr_r           <= pslverr_nxt;
			cmd_r               <= cmd_nxt;
			exec_left_r         <= exec_left_nxt;
			exec_valid_r        <= exec_valid_nxt;
			exec_data_r         <= exec_data_nxt;
			exec_last_r         <= exec_last_nxt;
		end
	end

	assign prdata          = prdata_r;
	// no wait states: every access ends in its first access cycle
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && pslverr_r;
	assign core_fetch_stop = debug_mode_flag_r;
	assign break_as_nop    = !breakpoint_enable_r;
	assign sys_reset       = rst_req_r;
	assign link_tx_valid   = ack_pend_r;
	assign link_tx_data    = `ODC_ACK_CHAR;
	assign exec_valid      = exec_valid_r;
	assign exec_data       = exec_data_r;
	assign exec_last       = exec_last_r;
	// level output, high until software clears or masks the cause
	assign irq             = |(irq_stat_r & irq_mask_r);
endmodule : odc_ctrl
`default_nettype wire

// ### inc/odc_consts.svh
// constants for the on-chip debug control and status block
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH

`define ODC_ADDR_CTL        12'h000
`define ODC_ADDR_STAT       12'h004
`define ODC_ADDR_IRQ_STAT   12'h008
`define ODC_ADDR_IRQ_MASK   12'h00c

`define ODC_CTL_DEBUG_MODE_FLAG     7
`define ODC_CTL_BREAKPOINT_ENABLE       6
`define ODC_CTL_ACKEN       5
`define ODC_CTL_RSTREQ      0
`define ODC_CTL_RESET       8'h00
`define ODC_CTL_WMASK       8'he1

`define ODC_STAT_DEBUG      7
`define ODC_STAT_HALT       6
`define ODC_STAT_RDPROT     5

`define ODC_OPC_BREAK       8'h00
`define ODC_ACK_CHAR        8'hff
`define ODC_CMD_EXEC        8'h12
`define ODC_EXEC_MAX        3'h5

`define ODC_IRQ_BREAK       0
`define ODC_IRQ_RSTDONE     1
`define ODC_IRQ_DISCARD     2
`define ODC_IRQ_W           3

`define ODC_RST_LEN_NS      64
`define ODC_CLK_NS          4
`define ODC_RST_CYCLES      ((`ODC_RST_LEN_NS + `ODC_CLK_NS - 1) / `ODC_CLK_NS)

`endif

// ### inc/odc_pkg.sv
// types for the on-chip debug control and status block
package odc_pkg;
	typedef enum logic [3:0] {
		ODC_CMD_IDLE  = 4'h1,
		ODC_CMD_LEN   = 4'h2,
		ODC_CMD_OPC   = 4'h4,
		ODC_CMD_DROP  = 4'h8
	} odc_cmd_state_t;
endpackage : odc_pkg

// ### verilog/odc_sync.sv
// three-stage synchroniser with agreement filter for one pin level
`timescale 1ns/100ps
`default_nettype none
module odc_sync (
	input  wire logic clk,    // system clock
	input  wire logic reset,  // synchronous reset
	input  wire logic din,    // asynchronous level
	output logic      dout    // filtered level
);
	logic [2:0] stage_r;
	logic [2:0] stage_nxt;
	logic       dout_r;
	logic       dout_nxt;

	always_comb begin
		stage_nxt = {stage_r[1:0], din};
		dout_nxt  = dout_r;
		// stage 0 is only read by stage 1
		if (stage_r[1] == stage_r[2]) begin
			dout_nxt = stage_r[2];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stage_r <= 3'h0;
			dout_r  <= 1'b0;
		end else begin
			stage_r <= stage_nxt;
			dout_r  <= dout_nxt;
		end
	end

	assign dout = dout_r;
endmodule : odc_sync
`default_nettype wire

// ### sim/odc_host.sv
// debug host model on the far side of the byte link
`timescale 1ns/100ps
`default_nettype none
module odc_host (
	input  wire logic       clk,      // system clock
	output logic            rx_valid, // byte to device
	output logic      [7:0] rx_data,  // byte value
	input  wire logic       tx_valid, // byte from device
	input  wire logic [7:0] tx_data,  // byte value
	output logic            tx_ready, // host takes byte
	output logic      [7:0] got       // last byte taken
);
	logic [1:0] wait_r;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		got = 8'h00;
		wait_r = 2'h0;
	end
	// a slow host: four cycles of stall before each byte is taken
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			got <= tx_data;
		tx_ready <= tx_valid && !tx_ready && wait_r == 2'h3;
		wait_r <= (tx_valid && !tx_ready) ? wait_r + 2'h1 : 2'h0;
	end
	task automatic send(input logic [7:0] q[$]);
		@(posedge clk);
		foreach (q[i]) begin
			rx_valid <= 1'b1;
			rx_data <= q[i];
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		// idle data is scrambled so a stale byte is never reused
		rx_data <= ~rx_data;
	endtask : send
endmodule : odc_host
`default_nettype wire

// ### sim/odc_ctrl_assertions.sv
// concurrent checks on the debug control block ports
`timescale 1ns/100ps
`default_nettype none
`include "odc_consts.svh"
module odc_ctrl_chk (
	input wire logic        clk,                       // clock
	input wire logic        reset,                     // reset
	input wire logic        psel,                      // apb
	input wire logic        penable,                   // apb
	input wire logic        pwrite,                    // apb
	input wire logic [11:0] paddr,                     // apb
	input wire logic [31:0] pwdata,                    // apb
	input wire logic [31:0] prdata,                    // apb
	input wire logic        pslverr,                   // apb
	input wire logic        flash_read_protect_option, // option
	input wire logic        core_decode,               // core
	input wire logic [7:0]  core_opcode,               // core
	input wire logic        core_fetch_stop,           // core
	input wire logic        break_as_nop,              // core
	input wire logic        sys_reset,                 // reset out
	input wire logic        link_tx_valid,             // link
	input wire logic [7:0]  link_tx_data,              // link
	input wire logic        link_tx_ready              // link
);
	logic [5:0] run_r;
	logic [5:0] run_nxt;
	logic       ctl_wr;
	always_comb begin
		run_nxt = sys_reset ? run_r + 6'h01 : 6'h00;
		ctl_wr = psel && penable && pwrite && paddr == `ODC_ADDR_CTL;
	end
	always_ff @(posedge clk) begin
		run_r <= reset ? 6'h00 : run_nxt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence brk_s;
		core_decode && core_opcode == `ODC_OPC_BREAK;
	endsequence
	break_set_a: assert property (brk_s ##0 !break_as_nop
		|=> core_fetch_stop) else $error("break did not stop the core");
	nop_keep_a: assert property (break_as_nop && !core_fetch_stop
		&& !ctl_wr |=> !core_fetch_stop)
		else $error("debug entered while disabled");
	protect_hold_a: assert property (flash_read_protect_option
		&& core_fetch_stop |=> core_fetch_stop) else $error("flag cleared");
	reset_stop_a: assert property (ctl_wr && pwdata[7:0] == 8'h81
		|-> ##[1:2] (core_fetch_stop && sys_reset)) else $error("no stop");
	enable_bit_a: assert property (ctl_wr |=>
		break_as_nop == !$past(pwdata[6])) else $error("enable bit wrong");
	unmapped_err_a: assert property (psel && penable
		&& paddr[11:4] != 8'h00 |-> pslverr) else $error("no slave error");
	ack_char_a: assert property (link_tx_valid |->
		link_tx_data == `ODC_ACK_CHAR) else $error("ack char wrong");
	tx_hold_a: assert property (link_tx_valid && !link_tx_ready
		|=> link_tx_valid) else $error("ack dropped");
	run_length_a: assert property ($fell(sys_reset)
		|-> run_r == 6'h10) else $error("reset request length wrong");
	status_read_a: assert property (psel && penable && !pwrite
		&& paddr == `ODC_ADDR_STAT |-> prdata[7] == $past(core_fetch_stop)
		&& prdata[5] != $past(flash_read_protect_option)
		&& prdata[4:0] == 5'h00) else $error("status read wrong");
endmodule : odc_ctrl_chk
bind odc_ctrl odc_ctrl_chk odc_ctrl_chk_inst (.clk, .reset, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
	.flash_read_protect_option, .core_decode, .core_opcode,
	.core_fetch_stop, .break_as_nop, .sys_reset, .link_tx_valid,
	.link_tx_data, .link_tx_ready);
`default_nettype wire

// ### sim/onchip_debug_control_status_tb.sv
// self-checking bench for the debug control and status block
`timescale 1ns/100ps
`default_nettype none
`include "odc_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module onchip_debug_control_status_tb;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, core_halted;
	logic flash_read_protect_option, core_decode, core_fetch_stop;
	logic break_as_nop, sys_reset, link_rx_valid, link_tx_valid;
	logic link_tx_ready, exec_valid, exec_last, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [7:0]  core_opcode, link_rx_data, link_tx_data, exec_data;
	logic [7:0]  got, last_r;
	logic [15:0] log_r;
	int          n, exec_n, cycles, miscompares, checked;
	odc_ctrl odc_ctrl_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .flash_read_protect_option,
		.core_halted, .core_decode, .core_opcode, .core_fetch_stop,
		.break_as_nop, .sys_reset, .link_rx_valid, .link_rx_data,
		.link_tx_valid, .link_tx_data, .link_tx_ready, .exec_valid,
		.exec_data, .exec_last, .irq);
	odc_host odc_host_inst (.clk, .rx_valid(link_rx_valid),
		.rx_data(link_rx_data), .tx_valid(link_tx_valid),
		.tx_data(link_tx_data), .tx_ready(link_tx_ready), .got);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (exec_valid) begin
			exec_n++;
			log_r <= {log_r[7:0], exec_data};
			if (exec_last)
				last_r <= exec_data;
		end
		if (cycles == 3000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		if (miscompares == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	task automatic do_reset();
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : do_reset
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rst_wait();
		// count the cycles in which the request stands, sampled mid-cycle
		n = 0;
		@(negedge clk);
		while (sys_reset === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		`CHK(n, `ODC_RST_CYCLES)
	endtask : rst_wait
	task automatic decode_brk();
		@(posedge clk);
		core_decode <= 1'b1;
		@(posedge clk);
		core_decode <= 1'b0;
		// room for the ack byte to get past the host's stall
		repeat (8) @(posedge clk);
	endtask : decode_brk
	task automatic t_regs();
		apb(0, `ODC_ADDR_CTL, 0);
		`CHK(rdata, 32'h0)
		apb(1, `ODC_ADDR_STAT, 32'hff);
		apb(0, `ODC_ADDR_STAT, 0);
		`CHK(rdata, 32'h20)
		apb(0, 12'h010, 0);
		`CHK(rdata, 32'h0)
		core_halted <= 1'b1;
		repeat (6) @(posedge clk);
		apb(0, `ODC_ADDR_STAT, 0);
		`CHK(rdata, 32'h60)
		core_halted <= 1'b0;
		decode_brk();
		apb(0, `ODC_ADDR_STAT, 0);
		`CHK(rdata, 32'h20)
	endtask : t_regs
	task automatic t_break();
		apb(1, `ODC_ADDR_CTL, 32'h60);
		decode_brk();
		`CHK(got, 8'hff)
		apb(0, `ODC_ADDR_STAT, 0);
		`CHK(rdata, 32'ha0)
		apb(0, `ODC_ADDR_IRQ_STAT, 0);
		`CHK(rdata[0], 1'b1)
		`CHK(irq, 1'b0)
		apb(1, `ODC_ADDR_IRQ_MASK, 32'h7);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		apb(1, `ODC_ADDR_IRQ_STAT, 32'h7);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		apb(1, `ODC_ADDR_CTL, 32'h40);
		apb(0, `ODC_ADDR_STAT, 0);
		`CHK(rdata, 32'h20)
		// another opcode with breakpoints on must leave the core running
		core_opcode <= 8'h01;
		decode_brk();
		core_opcode <= `ODC_OPC_BREAK;
		apb(0, `ODC_ADDR_STAT, 0);
		`CHK(rdata, 32'h20)
	endtask : t_break
	task automatic t_exec();
		apb(1, `ODC_ADDR_CTL, 32'h80);
		odc_host_inst.send('{8'h12, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
		repeat (3) @(posedge clk);
		`CHK(exec_n, 5)
		`CHK(log_r, 16'h0405)
		`CHK(last_r, 8'h05)
		// a length beyond five bytes aborts the command
		odc_host_inst.send('{8'h12, 8'h06, 8'h07});
		repeat (3) @(posedge clk);
		`CHK(exec_n, 5)
		apb(1, `ODC_ADDR_CTL, 0);
		odc_host_inst.send('{8'h12, 8'hcc});
		repeat (3) @(posedge clk);
		`CHK(exec_n, 5)
		apb(0, `ODC_ADDR_IRQ_STAT, 0);
		`CHK(rdata[2], 1'b1)
	endtask : t_exec
	task automatic t_protect();
		flash_read_protect_option <= 1'b1;
		apb(1, `ODC_ADDR_CTL, 32'h80);
		apb(1, `ODC_ADDR_CTL, 0);
		apb(0, `ODC_ADDR_CTL, 0);
		`CHK(rdata, 32'h80)
		apb(0, `ODC_ADDR_STAT, 0);
		`CHK(rdata, 32'h80)
		flash_read_protect_option <= 1'b0;
		do_reset();
		apb(0, `ODC_ADDR_CTL, 0);
		`CHK(rdata, 32'h0)
	endtask : t_protect
	task automatic t_rstreq();
		apb(1, `ODC_ADDR_CTL, 32'h81);
		rst_wait();
		apb(0, `ODC_ADDR_CTL, 0);
		`CHK(rdata, 32'h80)
		apb(1, `ODC_ADDR_CTL, 32'h41);
		rst_wait();
		apb(0, `ODC_ADDR_CTL, 0);
		`CHK(rdata, 32'h40)
		`CHK(core_fetch_stop, 1'b0)
	endtask : t_rstreq
	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, core_halted, core_decode} = 5'h00;
		flash_read_protect_option = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		core_opcode = `ODC_OPC_BREAK;
		do_reset();
		t_regs();
		t_break();
		t_exec();
		t_protect();
		t_rstreq();
		close_out();
	end
endmodule : onchip_debug_control_status_tb
`default_nettype wire
